/* src/firc_top.sv */
// Contract
// - Active frame sets status bit seven
// - Active frame flag drives request when enabled
// - Frame done or aborted sets end-of-message
// - Status read clears end-of-message flag
// - End-of-message drives request when enabled
// - Timer expiry sets bit five, four intervals
// - FIFO flag set by enabled service request
// - FIFO flag follows source, read-insensitive
// - FIFO flag drives request under master enable
// - FIFO reset clears full and not-empty
// - FIFO reset bit self-clears
// - Abort stops frame, raises end-of-message, empties FIFO
// - Abort cleared at frame end, transmit only
// - Empty FIFO: data-done end, else underrun
// - DMA terminal count sets data-done
// - Data-done clears at message end if empty
// - Back-to-back bit ends last frame on empty
// - Master enable low blocks all requests
// - Enable bits seven, six, five, four
`timescale 1ns/1ps
`include "firc_consts.svh"

module firc_top
  import firc_pkg::*;
#(
  parameter int TIMER_CYC_0 = `FIRC_TMR_US_0 * `FIRC_CLK_MHZ,
  parameter int TIMER_CYC_1 = `FIRC_TMR_US_1 * `FIRC_CLK_MHZ,
  parameter int TIMER_CYC_2 = `FIRC_TMR_US_2 * `FIRC_CLK_MHZ,
  parameter int TIMER_CYC_3 = `FIRC_TMR_US_3 * `FIRC_CLK_MHZ
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic [2:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  input  wire logic       active_frame_detect,
  input  wire logic       tx_mode,
  input  wire logic       dma_mode,
  input  wire logic       dma_terminal_count,
  input  wire logic       tx_service_request,
  input  wire logic       rx_service_request,
  input  wire logic       tx_frame_done,
  input  wire logic       fifo_empty,
  input  wire logic [1:0] timer_sel,
  output logic            irq,
  output logic            fifo_clear,
  output logic            tx_stop,
  output logic            tx_end_of_data,
  output logic            tx_underrun,
  output logic            tx_terminate_last
);

  localparam int TW = 32;

  logic [7:0]     master_r;
  logic [7:0]     ien_r;
  logic           flag_active_r;
  logic           end_of_message_flag_r;
  logic           flag_timer_r;
  logic           flag_fifo_r;
  logic           fifo_reset_r;
  logic           abort_r;
  logic           data_done_r;
  logic           back_to_back_last_frame_r;
  logic [TW-1:0]  tmr_cnt_r;
  logic           tmr_hit;
  logic           bank0;
  logic           wr_lca;
  logic           rd_stat;
  logic           abort_req;
  logic           msg_end;
  logic [7:0]     stat_val;
  logic [7:0]     lca_val;
  firc_tx_state_t tx_state_r;

  function automatic logic [TW-1:0] timer_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    timer_limit = TIMER_CYC_0[TW-1:0];
      2'h1:    timer_limit = TIMER_CYC_1[TW-1:0];
      2'h2:    timer_limit = TIMER_CYC_2[TW-1:0];
      default: timer_limit = TIMER_CYC_3[TW-1:0];
    endcase
  endfunction

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  assign bank0   = (master_r[`FIRC_BIT_BANK_HI:`FIRC_BIT_BANK_LO] == `FIRC_BANK0);
  assign wr_lca  = io_wr && bank0 && hit(io_addr, `FIRC_OFS_LINE_CTRL_A);
  assign rd_stat = io_rd && bank0 && hit(io_addr, `FIRC_OFS_IRQ_STATUS);
  // Abort only acts while transmit mode is set, whether or not a frame is being sent
  assign abort_req = wr_lca && io_wdata[`FIRC_BIT_ABORT] && tx_mode;
  assign tmr_hit = (tmr_cnt_r >= timer_limit(timer_sel) - 32'h1);
  // Data exhausted with data-done marks a clean message end
  assign msg_end = tx_mode && fifo_empty && data_done_r;

  always_comb begin
    stat_val = `FIRC_RST_ZERO;
    stat_val[`FIRC_BIT_ACTIVE] = flag_active_r;
    stat_val[`FIRC_BIT_END_MSG] = end_of_message_flag_r;
    stat_val[`FIRC_BIT_TIMER]  = flag_timer_r;
    stat_val[`FIRC_BIT_FIFO]   = flag_fifo_r;
  end

  always_comb begin
    lca_val = `FIRC_RST_ZERO;
    lca_val[`FIRC_BIT_FIFO_RESET] = fifo_reset_r;
    lca_val[`FIRC_BIT_ABORT]      = abort_r;
    lca_val[`FIRC_BIT_DATA_DONE]  = data_done_r;
    lca_val[`FIRC_BIT_B2B_LAST]   = back_to_back_last_frame_r;
  end

  // Master control and enables; bank bits pick the register set
  always_ff @(posedge clk) begin
    if (reset) begin
      master_r <= `FIRC_RST_MASTER_CTRL;
      ien_r    <= `FIRC_RST_IRQ_ENABLE;
    end else if (clk_en) begin
      if (io_wr && hit(io_addr, `FIRC_OFS_MASTER_CTRL)) begin
        master_r <= io_wdata & `FIRC_MASK_MASTER_CTRL;
      end
      if (io_wr && bank0 && hit(io_addr, `FIRC_OFS_IRQ_ENABLE)) begin
        ien_r <= io_wdata & `FIRC_MASK_IRQ_ENABLE;
      end
    end
  end

  // Interval timer runs freely and restarts on each expiry
  always_ff @(posedge clk) begin
    if (reset) begin
      tmr_cnt_r <= '0;
    end else if (clk_en) begin
      if (tmr_hit) begin
        tmr_cnt_r <= '0;
      end else begin
        tmr_cnt_r <= tmr_cnt_r + 32'h1;
      end
    end
  end

  // Active frame flag; a new event beats the read that clears it
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_active_r <= 1'b0;
    end else if (clk_en) begin
      if (active_frame_detect) begin
        flag_active_r <= 1'b1;
      end else if (rd_stat) begin
        flag_active_r <= 1'b0;
      end
    end
  end

  // Frame end, abort or clean data end; a read clears it unless one lands
  always_ff @(posedge clk) begin
    if (reset) begin
      end_of_message_flag_r <= 1'b0;
    end else if (clk_en) begin
      if ((tx_frame_done && tx_state_r != FIRC_TX_IDLE) || abort_req || msg_end) begin
        end_of_message_flag_r <= 1'b1;
      end else if (rd_stat) begin
        end_of_message_flag_r <= 1'b0;
      end
    end
  end

  // Timer flag, sticky until a status read
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_timer_r <= 1'b0;
    end else if (clk_en) begin
      if (tmr_hit) begin
        flag_timer_r <= 1'b1;
      end else if (rd_stat) begin
        flag_timer_r <= 1'b0;
      end
    end
  end

  // Level flag: follows the requests and is not touched by reads
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_fifo_r <= 1'b0;
    end else if (clk_en) begin
      flag_fifo_r <= ien_r[`FIRC_BIT_FIFO] &&
                     (tx_service_request || rx_service_request);
    end
  end

  // Transmit frame tracking
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state_r <= FIRC_TX_IDLE;
    end else if (clk_en) begin
      case (tx_state_r)
        FIRC_TX_IDLE: begin
          if (tx_mode && !fifo_empty) begin
            tx_state_r <= FIRC_TX_SEND;
          end
        end
        FIRC_TX_SEND: begin
          if (abort_req) begin
            tx_state_r <= FIRC_TX_ABORT;
          end else if (tx_frame_done || !tx_mode) begin
            tx_state_r <= FIRC_TX_IDLE;
          end
        end
        FIRC_TX_ABORT: begin
          if (tx_frame_done || !tx_mode) begin
            tx_state_r <= FIRC_TX_IDLE;
          end
        end
        default: tx_state_r <= FIRC_TX_IDLE;
      endcase
    end
  end

  // Reset bit lives one cycle, long enough for the FIFO to clear
  always_ff @(posedge clk) begin
    if (reset) begin
      fifo_reset_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_lca && io_wdata[`FIRC_BIT_FIFO_RESET]) begin
        fifo_reset_r <= 1'b1;
      end else begin
        fifo_reset_r <= 1'b0;
      end
    end
  end

  // Abort holds until the frame ends or transmit mode drops
  always_ff @(posedge clk) begin
    if (reset) begin
      abort_r <= 1'b0;
    end else if (clk_en) begin
      if (abort_req) begin
        abort_r <= 1'b1;
      end else if (tx_frame_done || !tx_mode) begin
        abort_r <= 1'b0;
      end
    end
  end

  // Plain host bit; the host sets it before the last frame
  always_ff @(posedge clk) begin
    if (reset) begin
      back_to_back_last_frame_r <= 1'b0;
    end else if (clk_en && wr_lca) begin
      back_to_back_last_frame_r <= io_wdata[`FIRC_BIT_B2B_LAST];
    end
  end

  // Terminal count wins over a same-cycle host write or end clear
  always_ff @(posedge clk) begin
    if (reset) begin
      data_done_r <= 1'b0;
    end else if (clk_en) begin
      if (tx_mode && dma_mode && dma_terminal_count) begin
        data_done_r <= 1'b1;
      end else if (wr_lca) begin
        data_done_r <= io_wdata[`FIRC_BIT_DATA_DONE];
      end else if ((msg_end || tx_frame_done) && fifo_empty) begin
        data_done_r <= 1'b0;
      end
    end
  end

  // Request line: each sticky flag with its enable, all behind the master bit
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= master_r[`FIRC_BIT_MASTER_IE] && (
             (flag_active_r && ien_r[`FIRC_BIT_ACTIVE]) ||
             (end_of_message_flag_r && ien_r[`FIRC_BIT_END_MSG]) ||
             (flag_timer_r && ien_r[`FIRC_BIT_TIMER]) ||
             flag_fifo_r);
    end
  end

  // One-cycle pulse after a reset write or a taken abort
  always_ff @(posedge clk) begin
    if (reset) begin
      fifo_clear <= 1'b0;
    end else if (clk_en) begin
      fifo_clear <= (wr_lca && io_wdata[`FIRC_BIT_FIFO_RESET]) || abort_req;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_stop <= 1'b0;
    end else if (clk_en) begin
      tx_stop <= abort_req;
    end
  end

  // Data exhausted with data-done set: a clean end
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_end_of_data <= 1'b0;
    end else if (clk_en) begin
      tx_end_of_data <= msg_end;
    end
  end

  // Data exhausted without data-done while sending: an underrun
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_underrun <= 1'b0;
    end else if (clk_en) begin
      tx_underrun <= tx_state_r == FIRC_TX_SEND && fifo_empty && !data_done_r;
    end
  end

  // Back-to-back last frame closes itself once the FIFO runs dry
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_terminate_last <= 1'b0;
    end else if (clk_en) begin
      tx_terminate_last <= tx_mode && back_to_back_last_frame_r && fifo_empty;
    end
  end

  // Read data, registered one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      io_rdata <= `FIRC_RST_ZERO;
    end else if (clk_en && io_rd) begin
      if (hit(io_addr, `FIRC_OFS_MASTER_CTRL)) begin
        io_rdata <= master_r;
      end else if (bank0 && hit(io_addr, `FIRC_OFS_IRQ_ENABLE)) begin
        io_rdata <= ien_r;
      end else if (rd_stat) begin
        io_rdata <= stat_val;
      end else if (bank0 && hit(io_addr, `FIRC_OFS_LINE_CTRL_A)) begin
        io_rdata <= lca_val;
      end else begin
        io_rdata <= `FIRC_RST_ZERO;
      end
    end
  end

endmodule

/* src/firc_consts.svh */
`ifndef FIRC_CONSTS_SVH
`define FIRC_CONSTS_SVH

// Register offsets within bank 0
`define FIRC_OFS_IRQ_ENABLE   3'h1
`define FIRC_OFS_IRQ_STATUS   3'h2
`define FIRC_OFS_LINE_CTRL_A  3'h3
`define FIRC_OFS_MASTER_CTRL  3'h7
`define FIRC_BANK0            2'h0

// Interrupt bit positions
`define FIRC_BIT_ACTIVE       7
`define FIRC_BIT_END_MSG      6
`define FIRC_BIT_TIMER        5
`define FIRC_BIT_FIFO         4

// Line control A bit positions
`define FIRC_BIT_FIFO_RESET   7
`define FIRC_BIT_ABORT        2
`define FIRC_BIT_DATA_DONE    1
`define FIRC_BIT_B2B_LAST     0

// Master control bit positions
`define FIRC_BIT_MASTER_IE    5
`define FIRC_BIT_BANK_HI      1
`define FIRC_BIT_BANK_LO      0

// Writable bits: bank select and master enable; enables in the top nibble
`define FIRC_MASK_MASTER_CTRL 8'h23
`define FIRC_MASK_IRQ_ENABLE  8'hf0

// Reset values
`define FIRC_RST_IRQ_ENABLE   8'h80
`define FIRC_RST_MASTER_CTRL  8'h00
`define FIRC_RST_ZERO         8'h00

// Timer intervals in microseconds
`define FIRC_TMR_US_0         500
`define FIRC_TMR_US_1         1000
`define FIRC_TMR_US_2         2000
`define FIRC_TMR_US_3         4000
`define FIRC_CLK_MHZ          125

`endif

/* src/firc_pkg.sv */
package firc_pkg;
  typedef enum logic [1:0] {
    FIRC_TX_IDLE,
    FIRC_TX_SEND,
    FIRC_TX_ABORT
  } firc_tx_state_t;
endpackage

/* testbench/firc_properties.sv */
`timescale 1ns/1ps
module firc_properties (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       clk_en,
  input wire logic [2:0] io_addr,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       active_frame_detect,
  input wire logic       tx_mode,
  input wire logic       tx_service_request,
  input wire logic       rx_service_request,
  input wire logic       tx_frame_done,
  input wire logic       fifo_empty,
  input wire logic       irq,
  input wire logic       fifo_clear,
  input wire logic       tx_stop,
  input wire logic       tx_end_of_data
);
  // Shadows of the enables; the bank is assumed to stay at zero
  logic       mie_r;
  logic [7:0] ie_r;
  logic       lca_wr;
  assign lca_wr = clk_en && io_wr && io_addr == 3'h3;
  always_ff @(posedge clk) begin
    if (reset) begin
      mie_r <= 1'b0;
      ie_r  <= 8'h80;
    end else if (clk_en && io_wr && io_addr == 3'h7) begin
      mie_r <= io_wdata[5];
    end else if (clk_en && io_wr && io_addr == 3'h1) begin
      ie_r <= io_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_quiet_rd;
    clk_en && io_rd && !io_wr && io_addr == 3'h2 && !tx_mode && !tx_frame_done
      && !active_frame_detect;
  endsequence
  sequence s_fifo_req;
    clk_en && mie_r && ie_r[4] && (tx_service_request || rx_service_request);
  endsequence
  sequence s_frame_seen;
    clk_en && !io_wr && active_frame_detect && mie_r && ie_r[7] ##1 clk_en && !io_wr;
  endsequence
  a_fifo_reset_pulse: assert property (lca_wr && io_wdata[7] |=> fifo_clear)
    else $error("no fifo clear after reset write");
  a_abort_stops_tx: assert property (lca_wr && io_wdata[2] && tx_mode |=> tx_stop && fifo_clear)
    else $error("abort did not stop and clear");
  a_abort_tx_only: assert property (lca_wr && io_wdata[2] && !tx_mode |=> !tx_stop)
    else $error("abort acted outside transmit");
  a_master_blocks: assert property (clk_en && !mie_r && !(io_wr && io_addr == 3'h7) |=> !irq)
    else $error("irq with master enable low");
  a_fifo_irq_on: assert property (s_fifo_req [*3] |-> irq)
    else $error("fifo request gave no irq");
  a_frame_irq_on: assert property (s_frame_seen |=> irq)
    else $error("active frame gave no irq");
  a_read_clears: assert property (s_quiet_rd ##1 s_quiet_rd |=> io_rdata[7:6] == 2'b00)
    else $error("status read left a sticky flag");
  a_reserved_zero: assert property (clk_en && io_rd && io_addr == 3'h2 |=> io_rdata[3:0] == 4'h0)
    else $error("reserved status bits not zero");
  a_eod_cause: assert property (tx_end_of_data && $past(clk_en) |-> $past(tx_mode) && $past(fifo_empty))
    else $error("end of data without empty fifo in transmit");
endmodule

/* testbench/firc_xcvr_model.sv */
`timescale 1ns/1ps
module firc_xcvr_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic fifo_clear,
  input  wire logic tx_stop,
  input  wire logic load,
  input  wire logic drain,
  output logic      fifo_empty,
  output logic      tx_frame_done
);
  // A clear wins over a load in the same cycle, as the real FIFO would
  always_ff @(posedge clk) begin
    if (reset || fifo_clear || drain) begin
      fifo_empty <= 1'b1;
    end else if (load) begin
      fifo_empty <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    tx_frame_done <= !reset && (drain || tx_stop);
  end
endmodule

/* testbench/test_fir_interrupt_tx_control.sv */
`timescale 1ns/1ps
module test_fir_interrupt_tx_control;
  logic       clk, reset, clk_en, io_wr, io_rd, active_frame_detect, tx_mode, dma_mode;
  logic       dma_terminal_count, tx_service_request, rx_service_request, load, drain;
  logic       tx_frame_done, fifo_empty, irq, fifo_clear, tx_stop, tx_end_of_data;
  logic       tx_underrun, tx_terminate_last;
  logic [2:0] io_addr;
  logic [1:0] timer_sel;
  logic [7:0] io_wdata, io_rdata, d, e;
  int         n_mismatch, samples_checked, n;
  int         tc[4] = '{50, 100, 200, 400};
  wire  [3:0] outs = {tx_terminate_last, tx_underrun, tx_end_of_data, irq};
  firc_top #(.TIMER_CYC_0(50), .TIMER_CYC_1(100), .TIMER_CYC_2(200), .TIMER_CYC_3(400))
    firc_top_i (.*);
  firc_xcvr_model firc_xcvr_model_i (.clk(clk), .reset(reset), .fifo_clear(fifo_clear),
    .tx_stop(tx_stop), .load(load), .drain(drain), .fifo_empty(fifo_empty),
    .tx_frame_done(tx_frame_done));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Strobes drop and one idle cycle follows, so calls never collide
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    v = io_rdata;
    @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic w(input int k, input logic v, input int lim);
    for (int i = 0; i < lim && outs[k] !== v; i++) @(negedge clk);
    chk(outs[k], v);
    if (outs[k] !== v) conclude();
  endtask
  task automatic t_active;
    rd(3'h1, d);
    chk(d, 8'h80);
    wr(3'h1, 8'h80);
    wr(3'h7, 8'h20);
    pulse(active_frame_detect);
    w(0, 1'b1, 4);
    wr(3'h7, 8'h00);
    w(0, 1'b0, 4);
    rd(3'h2, d);
    chk(d & 8'hdf, 8'h80);
    $display("test active done");
  endtask
  task automatic t_fifo;
    wr(3'h1, 8'h10);
    wr(3'h7, 8'h20);
    for (int k = 0; k < 2; k++) begin
      tx_service_request = (k == 0);
      rx_service_request = (k == 1);
      w(0, 1'b1, 4);
      rd(3'h2, d);
      rd(3'h2, e);
      chk(e & 8'hdf, 8'h10);
      {tx_service_request, rx_service_request} = 2'h0;
      w(0, 1'b0, 4);
    end
    $display("test fifo done");
  endtask
  task automatic t_abort;
    wr(3'h1, 8'h40);
    pulse(load);
    tx_mode = 1'b1;
    wr(3'h3, 8'h04);
    w(0, 1'b1, 4);
    chk(fifo_empty, 1'b1);
    // Abort bit drops on the edge that sees the frame end; read after it
    @(negedge clk);
    rd(3'h3, d);
    chk(d & 8'h04, 8'h00);
    tx_mode = 1'b0;
    wr(3'h3, 8'h04);
    io_addr = 3'h2;
    io_rd = 1'b1;
    @(negedge clk);
    d = io_rdata;
    @(negedge clk);
    io_rd = 1'b0;
    chk(d & 8'hdf, 8'h40);
    chk(io_rdata & 8'hdf, 8'h00);
    $display("test abort done");
  endtask
  task automatic t_tx;
    tx_mode = 1'b1;
    dma_mode = 1'b1;
    pulse(load);
    pulse(dma_terminal_count);
    rd(3'h3, d);
    chk(d & 8'h02, 8'h02);
    pulse(drain);
    w(1, 1'b1, 4);
    dma_mode = 1'b0;
    rd(3'h3, d);
    chk(d & 8'h02, 8'h00);
    pulse(load);
    wr(3'h3, 8'h03);
    rd(3'h3, d);
    chk(d & 8'h03, 8'h03);
    pulse(drain);
    w(3, 1'b1, 4);
    chk(tx_underrun, 1'b0);
    pulse(load);
    wr(3'h3, 8'h80);
    chk(fifo_empty, 1'b1);
    rd(3'h3, d);
    chk(d & 8'h80, 8'h00);
    chk(tx_underrun, 1'b1);
    tx_mode = 1'b0;
    $display("test transmit done");
  endtask
  task automatic t_timer;
    wr(3'h1, 8'h20);
    for (int s = 0; s < 4; s++) begin
      timer_sel = s[1:0];
      w(0, 1'b1, tc[s] + 8);
      rd(3'h2, d);
      w(0, 1'b1, tc[s] + 8);
      rd(3'h2, d);
      chk(d & 8'h20, 8'h20);
      for (n = 0; n < 500 && irq !== 1'b1; n++) @(negedge clk);
      chk(n >= tc[s] - 4 && n <= tc[s], 1'b1);
      if (irq !== 1'b1) conclude();
    end
    $display("test timer done");
  endtask
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    {io_wr, io_rd, active_frame_detect, tx_mode, dma_mode, dma_terminal_count, load, drain,
      tx_service_request, rx_service_request, io_addr, io_wdata, timer_sel} = '0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_active();
    t_fifo();
    t_abort();
    t_tx();
    t_timer();
    conclude();
  end
endmodule
bind firc_top firc_properties firc_properties_i (.*);
